//--- bench/psm_cpu_model.sv
// CPU-side partner: measures clocks between executed steps.
// Assumes step pulses on the system clock.
`timescale 1ns/1ns
module psm_cpu_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    input  wire logic        i_cpu_step,
    output logic      [15:0] o_gap
);
    logic [15:0] cnt; // Clocks since last step
    // Latch spacing at each step
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst) begin cnt <= '0; o_gap <= '0; end
        else if (i_cpu_step) begin o_gap <= cnt + 16'h0001; cnt <= '0; end
        else cnt <= cnt + 16'h0001;
    end
endmodule : psm_cpu_model

//--- bench/tb_top.sv
// Bench for the power-saving controller.
// Assumes AXI4-Lite slave and CPU pulses on one clock.
`timescale 1ns/1ns
module tb_top;
    logic clk = 0, nrst = 0, aw = 0, w = 0, br = 1, ar = 0, rr = 1;
    logic slp = 0, rfi = 0, ip = 0, global_int_enable = 0, wdt = 0, mc_n = 1, bor = 0, por = 0, xt = 0, crc = 0;
    logic [3:0] aa = 0, ra = 0, pact = 4'h0;
    logic [31:0] wd = 0;
    logic [2:0] oreq = 0;
    wire awr, wr_, bv, arr, rv, vec, inl, clken, rlp, drst, wblk, step;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] gap, tgap, fgap;
    wire tick, pf, abt, wclr, cpw;
    wire [2:0] osc;
    wire [3:0] phold;
    int errors = 0, n_compared = 0, cyc = 0, n, i, n_wclr = 0, n_abt = 0;
    logic [3:0] ta[6] = '{4'h0, 4'h0, 4'h4, 4'h4, 4'hC, 4'hC};
    logic [31:0] tw[6] = '{32'h0000_00FF, 0, 32'h0000_0002, 0, 32'h0000_0007, 0};
    logic [31:0] tx[6] = '{32'h0000_00F7, 0, 32'h0000_0003, 32'h0000_0001, 32'h0000_0007, 0};
    logic [2:0] dc[3] = '{3'h0, 3'h1, 3'h4};
    always #20 clk = ~clk;
    psm_ctrl i_psm_ctrl (.i_clk_sys(clk), .i_nrst(nrst), .i_awaddr(aa), .i_awvalid(aw), .o_awready(awr),
        .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(w), .o_wready(wr_), .o_bresp(bresp), .o_bvalid(bv),
        .i_bready(br), .i_araddr(ra), .i_arvalid(ar), .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rv), .i_rready(rr), .i_sleep_instr(slp), .i_return_from_interrupt(rfi),
        .i_int_pending(ip), .i_global_int_enable(global_int_enable), .i_wdt_timeout(wdt), .i_master_clear_pin_n(mc_n),
        .i_brownout(bor), .i_power_on(por), .i_crystal_mode(xt), .i_osc_periph_req(oreq),
        .i_converter_rc_osc(crc), .i_converter_on(1'b1), .i_port_periph_active(pact),
        .o_cpu_step(step), .o_pmem_fetch(pf), .o_periph_tick(tick), .o_sys_clk_en(clken), .o_osc_run(osc),
        .o_converter_abort(abt), .o_converter_power(cpw), .o_port_hold(phold), .o_wdt_clear(wclr),
        .o_wdt_reset_block(wblk), .o_device_reset(drst), .o_int_vector(vec), .o_resume_inline(inl),
        .o_regulator_lp(rlp));
    psm_cpu_model i_psm_cpu_model (.i_clk_sys(clk), .i_nrst(nrst), .i_cpu_step(step), .o_gap(gap));
    psm_cpu_model i_psm_cpu_model_tick (.i_clk_sys(clk), .i_nrst(nrst), .i_cpu_step(tick), .o_gap(tgap));
    psm_cpu_model i_psm_cpu_model_fetch (.i_clk_sys(clk), .i_nrst(nrst), .i_cpu_step(pf), .o_gap(fgap));
    // Compare and count
    task cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end
    endtask : cmp
    // Verdict and end of run
    task report_and_stop;
        if (errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    // Bus write, held per channel until taken
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        aa <= a; wd <= d; aw <= 1; w <= 1;
        do begin @(posedge clk); if (awr) aw <= 0; if (wr_) w <= 0; end while (!bv);
        cmp(bresp, er);
    endtask : wr
    // Bus read
    task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        ra <= a; ar <= 1;
        do begin @(posedge clk); if (arr) ar <= 0; end while (!rv);
        cmp(rdata, e);
        cmp(rresp, er);
    endtask : rd
    // Sleep instruction pulse
    task sl;
        slp <= 1; @(posedge clk); slp <= 0; repeat (3) @(posedge clk);
    endtask : sl
    // Wait for vector or inline resume pulse
    task wk(input bit il);
        n = 0;
        do begin @(posedge clk); n++; end while ((il ? inl : vec) !== 1'b1 && n < 3000);
        cmp(n < 3000, 1);
    endtask : wk
    // Hang guard
    always @(posedge clk) begin cyc++; n_wclr += wclr; n_abt += abt;
        if (cyc == 20000) begin errors++; report_and_stop; end end
    initial
    begin
        repeat (3) @(posedge clk); nrst <= 1; @(posedge clk);
        rd(4'h0, 0, 0); rd(4'h4, 1, 0); rd(4'h8, 32'h0000_0018, 0); rd(4'h2, 0, 2); wr(4'h6, 0, 2);
        for (i = 0; i < 6; i++) begin wr(ta[i], tw[i], 0); rd(ta[i], tx[i], 0); end
        for (i = 0; i < 3; i++) begin wr(0, 32'h40 | dc[i], 0); repeat (300) @(posedge clk);
            cmp(gap, 4 << (dc[i] + 1)); cmp(fgap, 4 << (dc[i] + 1)); cmp(tgap, 4); end
        wr(0, 32'h44, 0); ip <= 1; repeat (8) @(posedge clk); ip <= 0; rd(0, 32'h44, 0);
        wr(0, 32'h64, 0); global_int_enable <= 1; ip <= 1; wk(0); repeat (8) @(posedge clk); ip <= 0; rd(0, 32'h24, 0);
        repeat (20) @(posedge clk); cmp(gap, 4);
        wr(0, 32'h14, 0); rfi <= 1; @(posedge clk); rfi <= 0; rd(0, 32'h54, 0);
        wr(0, 0, 0); wr(4, 2, 0); wr(12, 1, 0); oreq <= 3'h2; pact <= 4'h5; sl; rd(8, 32'h12, 0);
        cmp(clken, 0); cmp(rlp, 1); cmp(osc, 3'h3); cmp(phold, 4'hA); cmp(cpw, 0);
        cmp(n_abt, 1); cmp(n_wclr, 1);
        global_int_enable <= 1; ip <= 1; wk(0); cmp(n >= 25, 1); cmp(n_wclr, 2); ip <= 0; rd(8, 32'h10, 0);
        wr(8, 32'h18, 0); ip <= 1; sl; rd(8, 32'h18, 0); ip <= 0;
        wr(0, 32'hE4, 0); sl; rd(8, 32'h11, 0); cmp(wblk, 1);
        ip <= 1; wk(0); ip <= 0; rd(0, 32'hA4, 0);
        wr(0, 32'hC4, 0); sl; wdt <= 1; @(posedge clk); wdt <= 0; repeat (4) @(posedge clk);
        rd(0, 32'hC4, 0); rd(8, 32'h10, 0); cmp(drst, 0);
        wr(4, 0, 0); wr(0, 0, 0); xt <= 1; global_int_enable <= 0; crc <= 1; sl; cmp(cpw, 1);
        ip <= 1; wk(1); cmp(n >= 1024, 1);
        ip <= 0; mc_n <= 0; repeat (5) @(posedge clk); cmp(drst, 1);
        nrst <= 0; mc_n <= 1; @(posedge clk); nrst <= 1; @(posedge clk);
        rd(8, 32'h18, 0); cmp(drst, 0); cmp(clken, 1);
        report_and_stop;
    end
endmodule : tb_top

//--- hw/psm_ctrl.sv
// Power-saving mode controller: doze throttling, idle, sleep and wake-up.
// Assumes a CPU core giving sleep and return pulses and interrupt levels
// on the same clock; reset and brown-out pins arrive asynchronously.
// Notes on behaviour
// - Doze runs one CPU cycle per ratio
// - Peripherals keep full speed while dozing
// - Without recover bit, ISR runs dozed
// - Recover bit clears doze on interrupt, not on sleep wake
// - Prefetched instruction runs before vectoring
// - Return with doze-on-exit sets doze
// - Sleep instruction picks idle or sleep
// - Idle halts CPU, peripherals keep clocks
// - Any interrupt ends idle, bit kept
// - Recover bit restores speed on interrupt wake from idle
// - Watchdog wakes idle, doze untouched
// - Sleep entry: flags, watchdog, clocks off
// - Oscillators kept by request or force
// - Converter aborts unless on RC clock
// - Idle ports hold their drive state
// - Pin resets reset; others resume
// - Watchdog cleared on every wake
// - Pending interrupt makes sleep a no-op
// - Late interrupt: sleep completes, wakes
// - Wake vectors if enabled, else inline
// - Crystal wake waits start-up delay
// - Low-power regulator selected in sleep
// - Ratio codes are powers of two
// - Low-power sleep adds wake delay
`timescale 1ns/1ns
module psm_ctrl #(
    parameter int N_PORTS = 4
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_nrst,
    input  wire logic [3:0]         i_awaddr,
    input  wire logic               i_awvalid,
    output logic                    o_awready,
    input  wire logic [31:0]        i_wdata,
    input  wire logic [3:0]         i_wstrb,
    input  wire logic               i_wvalid,
    output logic                    o_wready,
    output logic [1:0]              o_bresp,
    output logic                    o_bvalid,
    input  wire logic               i_bready,
    input  wire logic [3:0]         i_araddr,
    input  wire logic               i_arvalid,
    output logic                    o_arready,
    output logic [31:0]             o_rdata,
    output logic [1:0]              o_rresp,
    output logic                    o_rvalid,
    input  wire logic               i_rready,
    input  wire logic               i_sleep_instr,
    input  wire logic               i_return_from_interrupt,
    input  wire logic               i_int_pending,
    input  wire logic               i_global_int_enable,
    input  wire logic               i_wdt_timeout,
    input  wire logic               i_master_clear_pin_n,
    input  wire logic               i_brownout,
    input  wire logic               i_power_on,
    input  wire logic               i_crystal_mode,
    input  wire logic [2:0]         i_osc_periph_req,
    input  wire logic               i_converter_rc_osc,
    input  wire logic               i_converter_on,
    input  wire logic [N_PORTS-1:0] i_port_periph_active,
    output logic                    o_cpu_step,
    output logic                    o_pmem_fetch,
    output logic                    o_periph_tick,
    output logic                    o_sys_clk_en,
    output logic [2:0]              o_osc_run,
    output logic                    o_converter_abort,
    output logic                    o_converter_power,
    output logic [N_PORTS-1:0]      o_port_hold,
    output logic                    o_wdt_clear,
    output logic                    o_wdt_reset_block,
    output logic                    o_device_reset,
    output logic                    o_int_vector,
    output logic                    o_resume_inline,
    output logic                    o_regulator_lp
);
    // Elaboration check on the port count
    if (N_PORTS < 1 || N_PORTS > 32)
    begin : g_bad_ports
        $error("N_PORTS out of range");
    end

    // Last slot index of a doze period for a ratio code
    function automatic logic [7:0] f_last_slot(input logic [2:0] code);
        f_last_slot = 8'((9'h002 << code) - 9'h001);
    endfunction : f_last_slot

    psm_pkg::psm_state_t state;                  // Mode state
    logic [7:0]          ctrl;                   // Doze and idle control
    logic                regulator_power_mode;   // Low-power sleep select
    logic [2:0]          osc_force_enable_reg;   // Oscillator force bits
    logic                timeout_flag;           // Set on sleep entry
    logic                power_down_flag;        // Cleared on sleep entry
    logic [2:0]          sync_a;                 // Reset pins, first stage
    logic [2:0]          sync_b;                 // Reset pins, second stage
    logic [1:0]          icyc_div;               // Instruction cycle divider
    logic                icyc;                   // Instruction cycle enable
    logic [7:0]          slot;                   // Position in doze period
    logic                int_prev;               // Interrupt level, delayed
    logic                vec_pend;               // Vector after prefetch
    logic                wake_by_int;            // Wake cause was interrupt
    logic [10:0]         wake_cnt;               // Wake delay counter
    logic                aw_held;                // Write address taken
    logic                w_held;                 // Write data taken
    logic [3:0]          aw_addr;                // Held write address
    logic [7:0]          w_byte;                 // Held write byte
    logic                w_lane0;                // Byte lane 0 enabled

    wire logic doze_en  = ctrl[psm_pkg::BIT_DOZE_EN];
    wire logic recover_on_interrupt      = ctrl[psm_pkg::BIT_ROI];
    wire logic int_edge = i_int_pending & ~int_prev;
    wire logic in_run   = (state == psm_pkg::ST_RUN);
    wire logic sleep_go = in_run & i_sleep_instr & ~i_int_pending;
    wire logic sw_wr    = aw_held & w_held & ~o_bvalid;
    wire logic wr_ctrl  = sw_wr & w_lane0 & (aw_addr == psm_pkg::OFS_CTRL);
    wire logic roi_hit  = in_run & doze_en & recover_on_interrupt & int_edge;
    wire logic idle_int = (state == psm_pkg::ST_IDLE) & i_int_pending;
    wire logic idle_wdt = (state == psm_pkg::ST_IDLE) & i_wdt_timeout;
    wire logic slp_wake = (state == psm_pkg::ST_SLEEP) & (i_int_pending | i_wdt_timeout);
    wire logic in_slp   = (state == psm_pkg::ST_SLEEP);
    wire logic [10:0] wake_len = 11'((i_crystal_mode ? psm_pkg::OST_CYCLES : 0)
                                   + (regulator_power_mode ? psm_pkg::LP_WAKE_CYCLES : 0));

    // Reset pins cross into the clock domain
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end
        else
        begin
            sync_a <= {~i_master_clear_pin_n, i_brownout, i_power_on};
            sync_b <= sync_a;
        end
    end

    // Pin resets always reset, in sleep too
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            o_device_reset <= 1'b0;
        else
            o_device_reset <= |sync_b;
    end

    // Instruction cycle divider runs whenever clocks run
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            icyc_div <= 2'h0;
        else if (in_slp)
            icyc_div <= 2'h0;
        else
            icyc_div <= icyc_div + 2'h1;
    end
    assign icyc = (icyc_div == 2'(psm_pkg::ICYC_CLKS - 1));

    // Doze slot counter; a recover hit jumps to the active slot
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            slot <= 8'h00;
        else if (!doze_en || roi_hit)
            slot <= 8'h00;
        else if (icyc && in_run)
        begin
            if (slot >= f_last_slot(ctrl[2:0]))
                slot <= 8'h00;
            else
                slot <= slot + 8'h01;
        end
    end

    // Control register: software writes, hardware doze changes win
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            ctrl <= psm_pkg::RST_CTRL;
        else
        begin
            if (wr_ctrl)
                ctrl <= {w_byte[7:4], 1'b0, w_byte[2:0]};
            if (roi_hit || (idle_int && recover_on_interrupt))
                ctrl[psm_pkg::BIT_DOZE_EN] <= 1'b0;
            else if (in_run && i_return_from_interrupt && ctrl[psm_pkg::BIT_DOE])
                ctrl[psm_pkg::BIT_DOZE_EN] <= 1'b1;
            // Idle enable untouched by idle wakes; doze bit cleared by an interrupt wake of idle when recover bit is set
        end
    end

    // Regulator and oscillator force registers
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            regulator_power_mode <= psm_pkg::RST_PM;
            osc_force_enable_reg <= psm_pkg::RST_OSC;
        end
        else if (sw_wr && w_lane0)
        begin
            if (aw_addr == psm_pkg::OFS_REGU)
                regulator_power_mode <= w_byte[psm_pkg::BIT_REG_PM];
            if (aw_addr == psm_pkg::OFS_OSC)
                osc_force_enable_reg <= w_byte[2:0];
        end
    end

    // Status flags; a write of one rearms a flag, sleep entry wins
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            timeout_flag    <= psm_pkg::RST_FLAG;
            power_down_flag <= psm_pkg::RST_FLAG;
        end
        else if (sleep_go)
        begin
            timeout_flag    <= 1'b1;
            power_down_flag <= 1'b0;
        end
        else if (sw_wr && w_lane0 && aw_addr == psm_pkg::OFS_STATUS)
        begin
            if (w_byte[psm_pkg::BIT_TIMEOUT])
                timeout_flag <= 1'b1;
            if (w_byte[psm_pkg::BIT_PWR_DOWN])
                power_down_flag <= 1'b1;
        end
    end

    // Mode state machine
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state       <= psm_pkg::ST_RUN;
            wake_cnt    <= 11'h000;
            wake_by_int <= 1'b0;
        end
        else
        begin
            unique case (state)
                psm_pkg::ST_RUN:
                    if (sleep_go)
                        state <= ctrl[psm_pkg::BIT_IDLE_EN] ? psm_pkg::ST_IDLE
                                                            : psm_pkg::ST_SLEEP;
                psm_pkg::ST_IDLE:
                    if (i_int_pending || i_wdt_timeout)
                    begin
                        state       <= psm_pkg::ST_RUN;
                        wake_by_int <= i_int_pending;
                    end
                psm_pkg::ST_SLEEP:
                    if (slp_wake)
                    begin
                        state       <= psm_pkg::ST_WAKE;
                        wake_cnt    <= wake_len;
                        wake_by_int <= i_int_pending;
                    end
                psm_pkg::ST_WAKE:
                    if (wake_cnt == 11'h000)
                        state <= psm_pkg::ST_RUN;
                    else
                        wake_cnt <= wake_cnt - 11'h001;
            endcase
        end
    end

    // Interrupt edge and vector-after-prefetch tracking
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            int_prev <= 1'b0;
            vec_pend <= 1'b0;
        end
        else
        begin
            int_prev <= i_int_pending;
            if (roi_hit && i_global_int_enable)
                vec_pend <= 1'b1;
            else if (o_cpu_step)
                vec_pend <= 1'b0;
        end
    end

    // CPU, memory and peripheral cycle enables
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_cpu_step    <= 1'b0;
            o_pmem_fetch  <= 1'b0;
            o_periph_tick <= 1'b0;
            o_sys_clk_en  <= 1'b1;
        end
        else
        begin
            o_cpu_step    <= in_run & icyc & (~doze_en | slot == 8'h00);
            o_pmem_fetch  <= in_run & icyc & (~doze_en | slot == f_last_slot(ctrl[2:0]));
            o_periph_tick <= ~in_slp & icyc;
            o_sys_clk_en  <= ~(in_slp | sleep_go & ~ctrl[psm_pkg::BIT_IDLE_EN]);
        end
    end

    // Wake results: watchdog clear, vector or in-line resume
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_wdt_clear     <= 1'b0;
            o_int_vector    <= 1'b0;
            o_resume_inline <= 1'b0;
        end
        else
        begin
            o_wdt_clear <= sleep_go | slp_wake | idle_int | idle_wdt;
            if (state == psm_pkg::ST_WAKE && wake_cnt == 11'h000 || idle_int || idle_wdt)
            begin
                o_int_vector    <= (wake_by_int | idle_int) & i_global_int_enable;
                o_resume_inline <= ~((wake_by_int | idle_int) & i_global_int_enable);
            end
            else
            begin
                o_int_vector    <= vec_pend & o_cpu_step;
                o_resume_inline <= 1'b0;
            end
        end
    end

    // Sleep-time side effects on oscillators, converter, ports, regulator
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_osc_run         <= 3'h7;
            o_converter_abort <= 1'b0;
            o_converter_power <= 1'b0;
            o_port_hold       <= '0;
            o_wdt_reset_block <= 1'b0;
            o_regulator_lp    <= 1'b0;
        end
        else
        begin
            o_osc_run         <= in_slp ? (i_osc_periph_req | osc_force_enable_reg) : 3'h7;
            o_converter_abort <= sleep_go & ~i_converter_rc_osc;
            o_converter_power <= i_converter_on & (~in_slp | i_converter_rc_osc);
            o_port_hold       <= in_slp ? ~i_port_periph_active : '0;
            o_wdt_reset_block <= (state == psm_pkg::ST_IDLE) | in_slp;
            o_regulator_lp    <= in_slp & regulator_power_mode;
        end
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= 4'h0;
            w_byte   <= 8'h00;
            w_lane0  <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp  <= psm_pkg::RESP_OKAY;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready)
            begin
                w_held  <= 1'b1;
                w_byte  <= i_wdata[7:0];
                w_lane0 <= i_wstrb[0];
            end
            if (sw_wr)
            begin
                o_bvalid <= 1'b1;
                o_bresp  <= (aw_addr[1:0] == 2'h0) ? psm_pkg::RESP_OKAY : psm_pkg::RESP_SLVERR;
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
            end
            else if (o_bvalid && i_bready)
                o_bvalid <= 1'b0;
        end
    end

    // Ready flags: one write held at a time
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
        end
        else
        begin
            o_awready <= ~aw_held & ~(i_awvalid & o_awready) & ~o_bvalid;
            o_wready  <= ~w_held & ~(i_wvalid & o_wready) & ~o_bvalid;
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= psm_pkg::RESP_OKAY;
        end
        else
        begin
            o_arready <= ~o_rvalid & ~(i_arvalid & o_arready);
            if (i_arvalid && o_arready)
            begin
                o_rvalid <= 1'b1;
                o_rresp  <= psm_pkg::RESP_OKAY;
                unique case (i_araddr)
                    psm_pkg::OFS_CTRL:   o_rdata <= {24'h00_0000, ctrl};
                    psm_pkg::OFS_REGU:   o_rdata <= {30'h0, regulator_power_mode, 1'b1};
                    psm_pkg::OFS_STATUS: o_rdata <= {27'h0, timeout_flag, power_down_flag,
                                                     1'b0, in_slp, state == psm_pkg::ST_IDLE};
                    psm_pkg::OFS_OSC:    o_rdata <= {29'h0, osc_force_enable_reg};
                    default:
                    begin
                        o_rdata <= 32'h0000_0000;
                        o_rresp <= psm_pkg::RESP_SLVERR;
                    end
                endcase
            end
            else if (o_rvalid && i_rready)
                o_rvalid <= 1'b0;
        end
    end

    // Checks
    property p_noop;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        in_run && i_sleep_instr && i_int_pending |=> in_run && $stable(power_down_flag);
    endproperty
    a_noop: assert property (p_noop) else $error("sleep with pending int not a no-op");
    property p_entry;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        sleep_go |=> !power_down_flag && timeout_flag ##0 o_wdt_clear;
    endproperty
    a_entry: assert property (p_entry) else $error("sleep entry flags wrong");
    property p_mode;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        sleep_go |=> (state == psm_pkg::ST_IDLE) == $past(ctrl[psm_pkg::BIT_IDLE_EN]);
    endproperty
    a_mode: assert property (p_mode) else $error("wrong mode after sleep");
    property p_roi;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        roi_hit |=> !doze_en;
    endproperty
    a_roi: assert property (p_roi) else $error("recover did not clear doze");
    property p_wdt_idle;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        idle_wdt && !i_int_pending && !wr_ctrl |=> in_run && $stable(doze_en);
    endproperty
    a_wdt_idle: assert property (p_wdt_idle) else $error("watchdog idle wake wrong");
    property p_wake_clear;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        slp_wake |=> o_wdt_clear;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("watchdog not cleared on wake");
    property p_doze_gap;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_cpu_step && doze_en && $past(doze_en) && ctrl[2:0] == 3'h0 && in_run
            |=> !(o_cpu_step && doze_en) [*7];
    endproperty
    a_doze_gap: assert property (p_doze_gap) else $error("doze step too soon");
    property p_ost;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        slp_wake && i_crystal_mode |=> !in_run [*8];
    endproperty
    a_ost: assert property (p_ost) else $error("start-up delay skipped");
    property p_lp;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        in_slp && regulator_power_mode |=> o_regulator_lp;
    endproperty
    a_lp: assert property (p_lp) else $error("regulator not low power");
    c_idle: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) idle_int);
    c_sleep: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) slp_wake);
    c_roi: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) roi_hit);
endmodule : psm_ctrl

//--- hw/psm_pkg.sv
// Package for the power-saving mode controller.
// Assumes a 25 MHz system clock that is also the oscillator clock.
package psm_pkg;
    // Register byte offsets
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_REGU   = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_OSC    = 4'hC;
    // Control register fields
    localparam int BIT_IDLE_EN   = 7;
    localparam int BIT_DOZE_EN   = 6;
    localparam int BIT_ROI       = 5;
    localparam int BIT_DOE       = 4;
    localparam int BIT_RATIO_LO  = 0;
    // Regulator register fields
    localparam int BIT_REG_PM    = 1;
    localparam int BIT_REG_RSVD  = 0;
    // Status register fields
    localparam int BIT_TIMEOUT   = 4;
    localparam int BIT_PWR_DOWN  = 3;
    localparam int BIT_IN_SLEEP  = 1;
    localparam int BIT_IN_IDLE   = 0;
    // Reset values
    localparam logic [7:0] RST_CTRL  = 8'h00;
    localparam logic       RST_PM    = 1'b0;
    localparam logic       RST_FLAG  = 1'b1;
    localparam logic [2:0] RST_OSC   = 3'h0;
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int ICYC_CLKS     = 4;
    localparam int OST_TOSC      = 1024;
    localparam int OST_CYCLES    = OST_TOSC;
    localparam int LP_WAKE_NS    = 1000;
    localparam int LP_WAKE_CYCLES = (LP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Controller states
    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_IDLE  = 4'b0010,
        ST_SLEEP = 4'b0100,
        ST_WAKE  = 4'b1000
    } psm_state_t;
endpackage : psm_pkg
